//--- src/anx_pkg.sv
/*
 * Constants shared by the auto-negotiation next-page and indirect
 * device window register group: register indices, field
 * positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus, one register per word.
 */
package anx_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int         ADDR_W = 8;
    localparam int         DATA_W = 32;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_EXPANSION  = 6'h06;
    localparam logic [5:0] IDX_NP_TX      = 6'h07;
    localparam logic [5:0] IDX_NP_RX      = 6'h08;
    localparam logic [5:0] IDX_ACC_CTRL   = 6'h0d;
    localparam logic [5:0] IDX_ACC_DATA   = 6'h0e;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h21;

    // ****************************************************************
    // Expansion status fields
    // ****************************************************************
    localparam int EXP_LP_AN_BIT       = 0;
    localparam int EXP_PAGE_RX_BIT     = 1;
    localparam int EXP_NP_ABLE_BIT     = 2;
    localparam int EXP_LP_NP_BIT       = 3;
    localparam int EXP_PD_FAULT_BIT    = 4;
    localparam int EXP_NP_LOC_BIT      = 5;
    localparam int EXP_NP_LOC_ABLE_BIT = 6;

    // ****************************************************************
    // Next-page transmit / receive
    // ****************************************************************
    localparam logic [15:0] NPTX_WR_MASK    = 16'hb7ff;
    localparam logic [15:0] NPTX_RESET      = 16'h2001;
    localparam int          NPTX_TOGGLE_BIT = 11;
    localparam logic        NPTX_TOGGLE_RST = 1'b0;
    localparam logic [15:0] NPRX_RESET      = 16'h0000;

    // ****************************************************************
    // Indirect access control
    // ****************************************************************
    localparam int          CTRL_FUNC_LSB   = 14;
    localparam int          CTRL_DEV_MSB    = 4;
    localparam logic [1:0]  FUNC_ADDRESS    = 2'h0;
    localparam logic [1:0]  FUNC_DATA       = 2'h1;
    localparam logic [1:0]  FUNC_RESET      = 2'h0;
    localparam logic [4:0]  DEV_RESET       = 5'h00;
    localparam logic [4:0]  DEV_PCS         = 5'h03;
    localparam logic [4:0]  DEV_AUTONEG     = 5'h07;
    localparam logic [15:0] ACC_ADDR_RESET  = 16'h0000;

    // ****************************************************************
    // Interrupt status / mask
    // ****************************************************************
    localparam int         IRQ_W           = 2;
    localparam int         IRQ_PAGE_RX_BIT = 0;
    localparam int         IRQ_PD_FAULT_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RESET  = 2'h0;

endpackage : anx_pkg

//--- src/anx_top.sv
/*
 * Auto-negotiation expansion, next-page transmit/receive and indirect
 * manageable-device window registers behind an AXI4-Lite slave.
 * Assumes the negotiation engine and device register space run on
 * MCLK, so their signals need no synchroniser.
 */
// Notes on behaviour
// R1: Expansion bit 6 always reads 1, saying bit 5 reports the store.
// R2: Expansion bit 5 reads 1; partner next pages land at index 8.
// R3: Expansion bit 4 latches high on a parallel-detect fault, resets 0.
// R4: Expansion bit 1 latches high on a new received page, resets 0.
// R5: Bit 3 shows partner next-page ability; bit 2 is constant 1.
// R6: Bit 0 is 1 only once the partner is known to auto-negotiate.
// R7: Index 7 holds writable flags 15, 13, 12 and code 10:0, reset 2001.
// R8: Transmit toggle bit 11 is read-only and maintained by the device.
// R9: Index 8 is read-only, resets 0 and shows the partner's next page.
// R10: Control bits 15:14 pick the function; the host avoids 10 and 11.
// R11: Control bits 4:0 hold the target device number, reset 0.
// R12: With function 00 a write to index 14 sets the target address.
// R13: With other functions index 14 moves data at the latched address.
// R14: Data accesses never change the latched address.
// R15: The host sets address mode, address, data mode, then moves data.
`timescale 1ns/100ps
`default_nettype none

module anx_top
    import anx_pkg::*;
(
    input  wire logic                MCLK,
    input  wire logic                NRST,
    input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [DATA_W-1:0]   S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [DATA_W-1:0]        S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY,
    input  wire logic                AN_PAGE_RX,
    input  wire logic [15:0]         AN_RX_PAGE,
    input  wire logic                AN_PD_FAULT,
    input  wire logic                AN_LP_NP_ABLE,
    input  wire logic                AN_LP_AN_ABLE,
    input  wire logic                AN_TX_PAGE_SENT,
    output logic [15:0]              NP_TX_WORD,
    output logic [4:0]               TARGET_DEVICE_NUMBER,
    output logic [15:0]              MMD_ADDR,
    output logic [15:0]              MMD_WDATA,
    output logic                     MMD_WR,
    output logic                     MMD_RD,
    input  wire logic [15:0]         MMD_RDATA,
    output logic                     IRQ
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] anx_merge(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0]  strb
    );
        logic [15:0] res;
        res = old_val;
        if (strb[0])
        begin
            res[7:0] = new_val[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = new_val[15:8];
        end
        return res;
    endfunction : anx_merge

    // ****************************************************************
    // State
    // ****************************************************************
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [5:0]        aw_idx_reg;
    logic [15:0]       w_data_reg;
    logic [1:0]        w_strb_reg;
    logic              pd_fault_reg;
    logic              page_rx_reg;
    logic [15:0]       np_tx_reg;
    logic              toggle_reg;
    logic [15:0]       np_rx_reg;
    logic [1:0]        func_reg;
    logic [4:0]        dev_reg;
    logic [15:0]       acc_addr_reg;
    logic [IRQ_W-1:0]  irq_status_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;

    logic              wr_fire;
    logic              rd_fire;
    logic [5:0]        rd_idx;
    logic              wr_mapped;
    logic              rd_mapped;
    logic              clr_expansion;
    logic              clr_irq;
    logic [15:0]       ctrl_word;
    logic [15:0]       exp_word;
    logic [15:0]       rd_word;
    logic [15:0]       ctrl_merged;

    assign wr_fire = aw_full_reg && w_full_reg && !S_AXI_BVALID;
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_idx  = S_AXI_ARADDR[7:2];

    // Latched bits clear only on a read that is actually taken
    assign clr_expansion = rd_fire && (rd_idx == IDX_EXPANSION);
    assign clr_irq       = rd_fire && (rd_idx == IDX_IRQ_STATUS);

    assign ctrl_word = {func_reg, 9'h000, dev_reg};
    assign ctrl_merged = anx_merge(ctrl_word, w_data_reg, w_strb_reg);

    always_comb
    begin
        exp_word = 16'h0000;
        exp_word[EXP_NP_LOC_ABLE_BIT] = 1'b1;         // [R1]
        exp_word[EXP_NP_LOC_BIT]      = 1'b1;         // [R2]
        exp_word[EXP_PD_FAULT_BIT]    = pd_fault_reg; // [R3]
        exp_word[EXP_LP_NP_BIT]       = AN_LP_NP_ABLE; // [R5]
        exp_word[EXP_NP_ABLE_BIT]     = 1'b1;         // [R5]
        exp_word[EXP_PAGE_RX_BIT]     = page_rx_reg;  // [R4]
        exp_word[EXP_LP_AN_BIT]       = AN_LP_AN_ABLE; // [R6]
    end

    always_comb
    begin
        wr_mapped = 1'b1;
        case (aw_idx_reg)
            IDX_EXPANSION, IDX_NP_TX, IDX_NP_RX, IDX_ACC_CTRL,
            IDX_ACC_DATA, IDX_IRQ_STATUS, IDX_IRQ_MASK:
                wr_mapped = 1'b1;
            default:
                wr_mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        rd_word   = 16'h0000;
        rd_mapped = 1'b1;
        case (rd_idx)
            IDX_EXPANSION:  rd_word = exp_word;
            IDX_NP_TX:      rd_word = NP_TX_WORD;
            IDX_NP_RX:      rd_word = np_rx_reg;
            IDX_ACC_CTRL:   rd_word = ctrl_word;
            IDX_ACC_DATA:
            begin
                if (func_reg == FUNC_ADDRESS)
                begin
                    rd_word = acc_addr_reg;
                end
                else
                begin
                    rd_word = MMD_RDATA;                     // [R13]
                end
            end
            IDX_IRQ_STATUS: rd_word = {14'h0000, irq_status_reg};
            IDX_IRQ_MASK:   rd_word = {14'h0000, irq_mask_reg};
            default:        rd_mapped = 1'b0;
        endcase
    end

    // ****************************************************************
    // AXI4-Lite write channels
    // ****************************************************************
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            aw_full_reg   <= 1'b0;
            aw_idx_reg    <= 6'h00;
            S_AXI_AWREADY <= 1'b0;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_full_reg   <= 1'b1;
            aw_idx_reg    <= S_AXI_AWADDR[7:2];
            S_AXI_AWREADY <= 1'b0;
        end
        else if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            aw_full_reg   <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
        end
        else if (!aw_full_reg)
        begin
            S_AXI_AWREADY <= 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            w_full_reg   <= 1'b0;
            w_data_reg   <= 16'h0000;
            w_strb_reg   <= 2'h0;
            S_AXI_WREADY <= 1'b0;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= S_AXI_WDATA[15:0];
            w_strb_reg   <= S_AXI_WSTRB[1:0];
            S_AXI_WREADY <= 1'b0;
        end
        else if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            w_full_reg   <= 1'b0;
            S_AXI_WREADY <= 1'b1;
        end
        else if (!w_full_reg)
        begin
            S_AXI_WREADY <= 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
        begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channels
    // ****************************************************************
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= {16'h0000, rd_word};
            S_AXI_RRESP   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
        else if (!S_AXI_RVALID)
        begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ****************************************************************
    // Expansion latches (new event beats the read that clears)
    // ****************************************************************
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pd_fault_reg <= 1'b0;
            page_rx_reg  <= 1'b0;
        end
        else
        begin
            pd_fault_reg <= AN_PD_FAULT ||
                            (pd_fault_reg && !clr_expansion); // [R3]
            page_rx_reg  <= AN_PAGE_RX ||
                            (page_rx_reg && !clr_expansion);  // [R4]
        end
    end

    // ****************************************************************
    // Next-page transmit and receive
    // ****************************************************************
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            np_tx_reg <= NPTX_RESET;
        end
        else if (wr_fire && (aw_idx_reg == IDX_NP_TX))
        begin
            np_tx_reg <= anx_merge(np_tx_reg, w_data_reg, w_strb_reg)
                         & NPTX_WR_MASK;                      // [R7]
        end
    end

    // Flips once per page the engine has sent, so the partner sees
    // the alternation without software help
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            toggle_reg <= NPTX_TOGGLE_RST;
        end
        else if (AN_TX_PAGE_SENT)
        begin
            toggle_reg <= !toggle_reg;                        // [R8]
        end
    end

    always_comb
    begin
        NP_TX_WORD = np_tx_reg;
        NP_TX_WORD[NPTX_TOGGLE_BIT] = toggle_reg;             // [R8]
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            np_rx_reg <= NPRX_RESET;
        end
        else if (AN_PAGE_RX)
        begin
            np_rx_reg <= AN_RX_PAGE;                          // [R2] [R9]
        end
    end

    // ****************************************************************
    // Indirect device window
    // ****************************************************************
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            func_reg <= FUNC_RESET;
            dev_reg  <= DEV_RESET;
        end
        else if (wr_fire && (aw_idx_reg == IDX_ACC_CTRL))
        begin
            // Reserved codes are stored; they behave as data mode
            func_reg <= ctrl_merged[15:CTRL_FUNC_LSB];        // [R10]
            dev_reg  <= ctrl_merged[CTRL_DEV_MSB:0];          // [R11]
        end
    end

    assign TARGET_DEVICE_NUMBER = dev_reg;
    assign MMD_ADDR             = acc_addr_reg;

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            acc_addr_reg <= ACC_ADDR_RESET;
        end
        else if (wr_fire && (aw_idx_reg == IDX_ACC_DATA) &&
                 (func_reg == FUNC_ADDRESS))
        begin
            acc_addr_reg <= anx_merge(acc_addr_reg, w_data_reg,
                                      w_strb_reg);            // [R12] [R14]
        end
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            MMD_WR    <= 1'b0;
            MMD_RD    <= 1'b0;
            MMD_WDATA <= 16'h0000;
        end
        else
        begin
            MMD_WR <= wr_fire && (aw_idx_reg == IDX_ACC_DATA) &&
                      (func_reg != FUNC_ADDRESS);             // [R13]
            MMD_RD <= rd_fire && (rd_idx == IDX_ACC_DATA) &&
                      (func_reg != FUNC_ADDRESS);             // [R13]
            if (wr_fire && (aw_idx_reg == IDX_ACC_DATA))
            begin
                MMD_WDATA <= anx_merge(MMD_RDATA, w_data_reg,
                                       w_strb_reg);           // [R13]
            end
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            irq_status_reg <= '0;
        end
        else
        begin
            irq_status_reg[IRQ_PAGE_RX_BIT] <= AN_PAGE_RX ||
                (irq_status_reg[IRQ_PAGE_RX_BIT] && !clr_irq);
            irq_status_reg[IRQ_PD_FAULT_BIT] <= AN_PD_FAULT ||
                (irq_status_reg[IRQ_PD_FAULT_BIT] && !clr_irq);
        end
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end
        else if (wr_fire && (aw_idx_reg == IDX_IRQ_MASK) && w_strb_reg[0])
        begin
            irq_mask_reg <= w_data_reg[IRQ_W-1:0];
        end
    end

    // One cycle behind the status bits, in exchange for a clean flop
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            IRQ <= 1'b0;
        end
        else
        begin
            IRQ <= |(irq_status_reg & irq_mask_reg);
        end
    end

endmodule : anx_top

`default_nettype wire

//--- dv/anx_mmd_model.sv
/*
 * Model of the manageable-device register space behind the indirect
 * window: 32 words, combinational read, write on the strobe.
 * Assumes the same clock as anx_top and a settled device/address.
 */
`timescale 1ns/100ps
`default_nettype none
module anx_mmd_model
(
    input  wire logic        clk,
    input  wire logic [4:0]  dev,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    output logic [15:0]      rdata
);
    logic [15:0] mem [0:31];
    logic [4:0]  idx;

    // Only a few address bits decode; aliasing is harmless here
    assign idx   = {dev[1:0], addr[2:0]};
    assign rdata = mem[idx];

    // Non-zero contents so a stale zero never passes for data
    initial
    begin
        for (int i = 0; i < 32; i++)
            mem[i] = 16'h5a00 + 16'(i);
    end

    always @(posedge clk)
        if (wr)
            mem[idx] <= wdata;
endmodule : anx_mmd_model
`default_nettype wire

//--- dv/anx_assertions.sv
/*
 * Port-level properties of anx_top, attached by bind.
 * Assumes one clock MCLK and asynchronous active-low NRST.
 */
`timescale 1ns/100ps
`default_nettype none
module anx_checker
    import anx_pkg::*;
(
    input wire logic              MCLK,
    input wire logic              NRST,
    input wire logic              S_AXI_AWVALID,
    input wire logic              S_AXI_AWREADY,
    input wire logic              S_AXI_WVALID,
    input wire logic              S_AXI_WREADY,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic [DATA_W-1:0] S_AXI_RDATA,
    input wire logic              S_AXI_RVALID,
    input wire logic              S_AXI_RREADY,
    input wire logic              AN_TX_PAGE_SENT,
    input wire logic [15:0]       NP_TX_WORD,
    input wire logic [15:0]       MMD_ADDR,
    input wire logic              MMD_WR,
    input wire logic              MMD_RD,
    input wire logic              IRQ
);
    default clocking dcb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    AST_RD_LATENCY:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer not one cycle after address");
    AST_WR_LATENCY:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("write response not two cycles after request");
    AST_B_DONE:
    assert property (S_AXI_BVALID && S_AXI_BREADY
        |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
        else $error("write channel not freed after response");
    AST_R_DONE:
    assert property (S_AXI_RVALID && S_AXI_RREADY
        |=> !S_AXI_RVALID && S_AXI_ARREADY)
        else $error("read channel not freed after data");
    AST_RDATA_UPPER:
    assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("upper read half not zero");
    AST_TOGGLE_FLIP:
    assert property (AN_TX_PAGE_SENT
        |=> NP_TX_WORD[11] != $past(NP_TX_WORD[11]))
        else $error("toggle did not flip on sent page");
    AST_TOGGLE_HOLD:
    assert property (!AN_TX_PAGE_SENT |=> $stable(NP_TX_WORD[11]))
        else $error("toggle moved without sent page");
    AST_NPTX_RSVD:
    assert property (NP_TX_WORD[14] == 1'b0)
        else $error("reserved transmit bit set");
    AST_ADDR_HOLD:
    assert property (MMD_WR || MMD_RD |-> $stable(MMD_ADDR))
        else $error("address moved on data access");
    AST_WR_PULSE:
    assert property (MMD_WR |=> !MMD_WR)
        else $error("device write strobe longer than one cycle");

    cover property (MMD_WR);
    cover property (MMD_RD);
    cover property ($rose(IRQ));
endmodule : anx_checker

bind anx_top anx_checker u_anx_checker (.*);
`default_nettype wire

//--- dv/autoneg_nextpage_mmd_access_tb.sv
/*
 * Self-checking bench for anx_top: register rows, then events,
 * toggle and the indirect window.
 * Assumes anx_mmd_model stands behind the window.
 */
`timescale 1ns/100ps
`default_nettype none
module autoneg_nextpage_mmd_access_tb
    import anx_pkg::*;
();
    typedef struct {
        logic [7:0]  addr;
        logic [15:0] rst;
        logic [15:0] wd;
        logic [15:0] rd;
        logic [1:0]  resp;
    } anx_row_s;

    logic mclk = 1'b0, nrst = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic page_rx = 1'b0, pd_fault = 1'b0, tx_sent = 1'b0;
    logic np_able = 1'b0, an_able = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic [15:0] rx_page = 16'h0000;
    logic awready, wready, bvalid, arready, rvalid, mmd_wr, mmd_rd, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd_data;
    logic [15:0] np_tx_word, mmd_addr, mmd_wdata, mmd_rdata;
    logic [4:0]  dev_num;
    int          n_errors = 0;
    int          checked = 0;

    anx_row_s rows [8] = '{
        '{8'h18, 16'h0064, 16'hffff, 16'h0064, RESP_OKAY},
        '{8'h1c, 16'h2001, 16'hffff, 16'hb7ff, RESP_OKAY},
        '{8'h1c, 16'hb7ff, 16'h0000, 16'h0000, RESP_OKAY},
        '{8'h20, 16'h0000, 16'hffff, 16'h0000, RESP_OKAY},
        '{8'h34, 16'h0000, 16'h7fe7, 16'h4007, RESP_OKAY},
        '{8'h34, 16'h4007, 16'h0003, 16'h0003, RESP_OKAY},
        '{8'h38, 16'h0000, 16'h1234, 16'h1234, RESP_OKAY},
        '{8'h3c, 16'h0000, 16'hffff, 16'h0000, RESP_SLVERR}};

    always #5 mclk = ~mclk;

    anx_top dut (
        .MCLK(mclk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .AN_PAGE_RX(page_rx), .AN_RX_PAGE(rx_page),
        .AN_PD_FAULT(pd_fault), .AN_LP_NP_ABLE(np_able),
        .AN_LP_AN_ABLE(an_able), .AN_TX_PAGE_SENT(tx_sent),
        .NP_TX_WORD(np_tx_word), .TARGET_DEVICE_NUMBER(dev_num),
        .MMD_ADDR(mmd_addr), .MMD_WDATA(mmd_wdata), .MMD_WR(mmd_wr),
        .MMD_RD(mmd_rd), .MMD_RDATA(mmd_rdata), .IRQ(irq));

    anx_mmd_model u_mmd (.clk(mclk), .dev(dev_num), .addr(mmd_addr),
        .wdata(mmd_wdata), .wr(mmd_wr), .rdata(mmd_rdata));

    task automatic check(input string what, input logic [15:0] got,
                         input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s = 4'hf);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (!bvalid)
            @(posedge mclk);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        rd_data = rdata;
        resp    = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        check($sformatf("reg %h", a), rd_data[15:0], e);
    endtask : rd_chk

    task automatic stop_test();
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check("np_tx_word", np_tx_word, 16'h2001);
        foreach (rows[i])
        begin
            rd_chk(rows[i].addr, rows[i].rst);
            wr(rows[i].addr, rows[i].wd);
            check("bresp", {14'h0000, resp}, {14'h0000, rows[i].resp});
            rd_chk(rows[i].addr, rows[i].rd);
            check("rresp", {14'h0000, resp}, {14'h0000, rows[i].resp});
        end
        check("mmd_addr", mmd_addr, 16'h1234);
        wr(8'h84, 16'h0003);
        np_able  <= 1'b1;
        an_able  <= 1'b1;
        rx_page  <= 16'hd8a5;
        page_rx  <= 1'b1;
        pd_fault <= 1'b1;
        @(posedge mclk);
        page_rx  <= 1'b0;
        pd_fault <= 1'b0;
        repeat (2) @(posedge mclk);
        check("irq", {15'h0000, irq}, 16'h0001);
        rd_chk(8'h18, 16'h007f);
        rd_chk(8'h18, 16'h006d);
        rd_chk(8'h20, 16'hd8a5);
        rd_chk(8'h80, 16'h0003);
        rd_chk(8'h80, 16'h0000);
        check("irq", {15'h0000, irq}, 16'h0000);
        // Masked event still latches status but keeps the line low
        wr(8'h84, 16'h0000);
        pd_fault <= 1'b1;
        @(posedge mclk);
        pd_fault <= 1'b0;
        repeat (2) @(posedge mclk);
        check("irq", {15'h0000, irq}, 16'h0000);
        rd_chk(8'h80, 16'h0002);
        tx_sent <= 1'b1;
        @(posedge mclk);
        tx_sent <= 1'b0;
        wr(8'h1c, 16'hffff);
        rd_chk(8'h1c, 16'hbfff);
        check("np_tx_word", np_tx_word, 16'hbfff);
        wr(8'h34, 16'h0007);
        wr(8'h38, 16'h0005);
        wr(8'h34, 16'h4007);
        check("dev", {11'h000, dev_num}, 16'h0007);
        check("mmd_addr", mmd_addr, 16'h0005);
        wr(8'h38, 16'hbeef);
        rd_chk(8'h38, 16'hbeef);
        wr(8'h38, 16'h00aa, 4'h1);
        rd_chk(8'h38, 16'hbeaa);
        check("mmd_addr", mmd_addr, 16'h0005);
        stop_test();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge mclk);
        n_errors++;
        stop_test();
    end
endmodule : autoneg_nextpage_mmd_access_tb
`default_nettype wire
